// *** verilog/srcp_pkg.sv ***
// Purpose: constants and types for the sample rate converter data port
// Assumes: AXI4-Lite slave, 32-bit data, one aligned word per register
// Notes: register indices times four give the byte addresses
// Summary of operation
// - At most ten channels in total, spread over at most three rate pairs.
// - Each pair carries an even count of zero to ten channels.
// - After reset or a cleared input enable, the pair polls without interrupts.
// - Each input sampling clock rising edge removes one sample per enabled FIFO.
// - Input words below threshold set the pair's data-needed flag.
// - Input threshold defaults to thirty-two samples.
// - Fetching from an empty input FIFO sets the overload error flag.
// - All input FIFOs above threshold clear the data-needed flag by hardware.
// - Each input port word goes to the next channel FIFO in rotation.
// - A readable counter shows which channel gets the next input word.
// - With input interrupt enabled, below threshold also raises an interrupt request.
// - With overload interrupt enabled, an empty fetch raises an interrupt request.
// - Data-needed flags double as DMA requests; DMA writes the input port.
// - Output FIFOs have a polling handshake with own status, sharing the input threshold.
// - Output FIFOs have an interrupt mode mirroring the input one.
// - Output-ready flags double as DMA read requests.
// - Samples move only through bus registers; sampling clocks wire in directly.
package srcp_pkg;
  localparam int NPAIR = 3;
  localparam int MAXCH = 10;
  localparam int DEPTH = 64;
  localparam int DW = 24;
  localparam int AW = 7;
  localparam int THR_RST = 32;
  localparam int NCW = 4;
  localparam int IE_OUT = 3;
  localparam int IE_OVL = 6;
  localparam logic [3:0] NCH_MAX = 4'hA;
  localparam logic [4:0] IX_CTRL = 5'h00;
  localparam logic [4:0] IX_IER = 5'h01;
  localparam logic [4:0] IX_CNCR = 5'h03;
  localparam logic [4:0] IX_STR = 5'h08;
  localparam logic [4:0] IX_CCR = 5'h17;
  localparam logic [4:0] IX_THR = 5'h1E;
  localparam logic [4:0] IX_DI [NPAIR] = '{5'h18, 5'h1A, 5'h1C};
  localparam logic [4:0] IX_DO [NPAIR] = '{5'h19, 5'h1B, 5'h1D};
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [2:0] {
    BS_IDLE = 3'b001,
    BS_WR = 3'b010,
    BS_RD = 3'b100
  } srcp_bus_type;
  typedef struct packed {
    logic ovl_irq;
    logic [NPAIR-1:0] out_irq;
    logic [NPAIR-1:0] in_irq;
    logic [NPAIR-1:0] out_dma;
    logic [NPAIR-1:0] in_dma;
  } srcp_req_type;
endpackage

// *** verilog/srcp_top.sv ***
// Purpose: sample FIFOs and request flags of the rate converter data port
// Assumes: sampling clocks are asynchronous pins, one bus clock
// Notes: consumed input samples loop into the output FIFOs in place of the filter
`timescale 1ns/1ps
module srcp_top #(
  parameter int DEPTH = srcp_pkg::DEPTH
) (
  input logic aclk,
  input logic aresetn,
  input logic [srcp_pkg::AW-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [srcp_pkg::AW-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [srcp_pkg::NPAIR-1:0] samp_clk_in,
  output srcp_pkg::srcp_req_type req
);
  localparam int NP = srcp_pkg::NPAIR;
  localparam int MC = srcp_pkg::MAXCH;
  localparam int NW = srcp_pkg::NCW;
  localparam int NF = NP * MC;
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [srcp_pkg::DW-1:0] in_mem [NF][DEPTH];
  logic [srcp_pkg::DW-1:0] out_mem [NF][DEPTH];
  logic [PW-1:0] iwp_r [NF], iwp_nxt [NF], irp_r [NF], irp_nxt [NF];
  logic [PW-1:0] owp_r [NF], owp_nxt [NF], orp_r [NF], orp_nxt [NF];
  logic [CW-1:0] icnt_r [NF], icnt_nxt [NF], ocnt_r [NF], ocnt_nxt [NF];
  logic [NF-1:0] ipush, ipop, opush, opop;
  logic [NP-1:0] ctrl_r, ctrl_nxt, need_r, need_nxt, rdy_r, rdy_nxt;
  logic [NP-1:0] lo_v, hi_v, olo_v, ohi_v;
  logic [6:0] ier_r, ier_nxt;
  logic [NP*NW-1:0] cncr_r, cncr_nxt, icc_r, icc_nxt, occ_r, occ_nxt;
  logic [CW-1:0] thr_r, thr_nxt;
  logic ovl_r, ovl_nxt, ovl_set, ovl_clr, cfg_ok;
  logic [NP-1:0] s1_r, s2_r, s3_r, edge_v;
  srcp_pkg::srcp_bus_type st_r, st_nxt;
  logic awrdy_r, awrdy_nxt, ardy_r, ardy_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  srcp_pkg::srcp_req_type req_r, req_nxt;
  logic [4:0] wi, ri;

  assign wi = s_axi_awaddr[srcp_pkg::AW-1:2];
  assign ri = s_axi_araddr[srcp_pkg::AW-1:2];
  assign edge_v = s2_r & ~s3_r;
  assign s_axi_awready = awrdy_r;
  assign s_axi_wready = awrdy_r;
  assign s_axi_arready = ardy_r;
  assign s_axi_bvalid = st_r[1];
  assign s_axi_rvalid = st_r[2];
  assign s_axi_bresp = bresp_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign req = req_r;

  always_comb begin
    int f;
    int sum;
    logic [NW-1:0] n;
    logic [NW-1:0] k;
    f = 0;
    sum = 0;
    n = '0;
    k = '0;
    st_nxt = st_r;
    awrdy_nxt = 1'b0;
    ardy_nxt = 1'b0;
    bresp_nxt = bresp_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    ctrl_nxt = ctrl_r;
    ier_nxt = ier_r;
    cncr_nxt = cncr_r;
    thr_nxt = thr_r;
    icc_nxt = icc_r;
    occ_nxt = occ_r;
    ipush = '0;
    ipop = '0;
    opush = '0;
    opop = '0;
    ovl_set = 1'b0;
    ovl_clr = 1'b0;
    cfg_ok = 1'b1;
    for (int p = 0; p < NP; p++) begin
      n = s_axi_wdata[p*NW +: NW];
      if (n[0] || n > srcp_pkg::NCH_MAX) cfg_ok = 1'b0;
      sum = sum + int'(n);
    end
    if (sum > MC) cfg_ok = 1'b0;
    case (st_r)
      srcp_pkg::BS_IDLE: begin
        if (awrdy_r) begin
          st_nxt = srcp_pkg::BS_WR;
          bresp_nxt = srcp_pkg::RESP_OK;
          if (wi == srcp_pkg::IX_CTRL) begin
            if (s_axi_wstrb[0]) ctrl_nxt = s_axi_wdata[NP-1:0];
          end else if (wi == srcp_pkg::IX_IER) begin
            if (s_axi_wstrb[0]) ier_nxt = s_axi_wdata[6:0];
          end else if (wi == srcp_pkg::IX_CNCR) begin
            if (&s_axi_wstrb[1:0] && cfg_ok) begin
              cncr_nxt = s_axi_wdata[NP*NW-1:0];
              icc_nxt = '0;
              occ_nxt = '0;
            end
          end else if (wi == srcp_pkg::IX_STR) begin
            ovl_clr = s_axi_wstrb[0] & s_axi_wdata[srcp_pkg::IE_OVL];
          end else if (wi == srcp_pkg::IX_THR) begin
            if (s_axi_wstrb[0]) thr_nxt = s_axi_wdata[CW-1:0];
          end else if (wi != srcp_pkg::IX_CCR) begin
            bresp_nxt = srcp_pkg::RESP_ERR;
            for (int p = 0; p < NP; p++) begin
              n = cncr_r[p*NW +: NW];
              k = icc_r[p*NW +: NW];
              if (wi == srcp_pkg::IX_DO[p]) bresp_nxt = srcp_pkg::RESP_OK;
              if (wi == srcp_pkg::IX_DI[p]) begin
                bresp_nxt = srcp_pkg::RESP_OK;
                if (n != '0 && &s_axi_wstrb[2:0]) begin
                  f = p * MC + int'(k);
                  ipush[f] = icnt_r[f] != FULL;
                  icc_nxt[p*NW +: NW] = (k + 1'b1 == n) ? '0 : k + 1'b1;
                end
              end
            end
          end
        end else if (ardy_r) begin
          st_nxt = srcp_pkg::BS_RD;
          rresp_nxt = srcp_pkg::RESP_OK;
          rdata_nxt = '0;
          if (ri == srcp_pkg::IX_CTRL) begin
            rdata_nxt = 32'(ctrl_r);
          end else if (ri == srcp_pkg::IX_IER) begin
            rdata_nxt = 32'(ier_r);
          end else if (ri == srcp_pkg::IX_CNCR) begin
            rdata_nxt = 32'(cncr_r);
          end else if (ri == srcp_pkg::IX_STR) begin
            rdata_nxt = 32'({ovl_r, rdy_r, need_r});
          end else if (ri == srcp_pkg::IX_THR) begin
            rdata_nxt = 32'(thr_r);
          end else if (ri == srcp_pkg::IX_CCR) begin
            rdata_nxt = 32'({occ_r, icc_r});
          end else begin
            rresp_nxt = srcp_pkg::RESP_ERR;
            for (int p = 0; p < NP; p++) begin
              n = cncr_r[p*NW +: NW];
              k = occ_r[p*NW +: NW];
              if (ri == srcp_pkg::IX_DI[p]) rresp_nxt = srcp_pkg::RESP_OK;
              if (ri == srcp_pkg::IX_DO[p]) begin
                rresp_nxt = srcp_pkg::RESP_OK;
                if (n != '0) begin
                  f = p * MC + int'(k);
                  opop[f] = ocnt_r[f] != '0;
                  if (opop[f]) rdata_nxt = 32'(out_mem[f][orp_r[f]]);
                  occ_nxt[p*NW +: NW] = (k + 1'b1 == n) ? '0 : k + 1'b1;
                end
              end
            end
          end
        end else if (s_axi_awvalid && s_axi_wvalid) begin
          awrdy_nxt = 1'b1;
        end else if (s_axi_arvalid) begin
          ardy_nxt = 1'b1;
        end
      end
      srcp_pkg::BS_WR: begin
        if (s_axi_bready) st_nxt = srcp_pkg::BS_IDLE;
      end
      srcp_pkg::BS_RD: begin
        if (s_axi_rready) st_nxt = srcp_pkg::BS_IDLE;
      end
      default: st_nxt = srcp_pkg::BS_IDLE;
    endcase
    // An empty fetch sets the overload flag and pushes no output word; the other channels still pop
    for (int p = 0; p < NP; p++) begin
      n = cncr_r[p*NW +: NW];
      for (int c = 0; c < MC; c++) begin
        f = p * MC + c;
        if (edge_v[p] && ctrl_r[p] && NW'(c) < n) begin
          ipop[f] = icnt_r[f] != '0;
          opush[f] = ipop[f] && ocnt_r[f] != FULL;
          if (!ipop[f]) ovl_set = 1'b1;
        end
      end
    end
    for (int i = 0; i < NF; i++) begin
      iwp_nxt[i] = iwp_r[i] + PW'(ipush[i]);
      irp_nxt[i] = irp_r[i] + PW'(ipop[i]);
      owp_nxt[i] = owp_r[i] + PW'(opush[i]);
      orp_nxt[i] = orp_r[i] + PW'(opop[i]);
      icnt_nxt[i] = icnt_r[i] + CW'(ipush[i]) - CW'(ipop[i]);
      ocnt_nxt[i] = ocnt_r[i] + CW'(opush[i]) - CW'(opop[i]);
    end
    // Equal to threshold holds the flag, giving hysteresis of one word
    for (int p = 0; p < NP; p++) begin
      n = cncr_r[p*NW +: NW];
      lo_v[p] = 1'b0;
      olo_v[p] = 1'b0;
      hi_v[p] = n != '0;
      ohi_v[p] = n != '0;
      for (int c = 0; c < MC; c++) begin
        f = p * MC + c;
        if (NW'(c) < n) begin
          if (icnt_nxt[f] < thr_r) lo_v[p] = 1'b1;
          if (icnt_nxt[f] <= thr_r) hi_v[p] = 1'b0;
          if (ocnt_nxt[f] < thr_r) olo_v[p] = 1'b1;
          if (ocnt_nxt[f] <= thr_r) ohi_v[p] = 1'b0;
        end
      end
      need_nxt[p] = (n != '0) && (lo_v[p] || (need_r[p] && !hi_v[p]));
      rdy_nxt[p] = (n != '0) && !olo_v[p] && (ohi_v[p] || rdy_r[p]);
    end
    ovl_nxt = ovl_set | (ovl_r & ~ovl_clr);
    req_nxt.in_dma = need_nxt;
    req_nxt.out_dma = rdy_nxt;
    req_nxt.in_irq = need_nxt & ier_nxt[NP-1:0];
    req_nxt.out_irq = rdy_nxt & ier_nxt[srcp_pkg::IE_OUT +: NP];
    req_nxt.ovl_irq = ovl_nxt & ier_nxt[srcp_pkg::IE_OVL];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= srcp_pkg::BS_IDLE;
      awrdy_r <= 1'b0;
      ardy_r <= 1'b0;
      bresp_r <= srcp_pkg::RESP_OK;
      rresp_r <= srcp_pkg::RESP_OK;
      rdata_r <= '0;
      ctrl_r <= '0;
      ier_r <= '0;
      cncr_r <= '0;
      thr_r <= CW'(srcp_pkg::THR_RST);
      icc_r <= '0;
      occ_r <= '0;
      need_r <= '0;
      rdy_r <= '0;
      ovl_r <= 1'b0;
      req_r <= '0;
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      for (int i = 0; i < NF; i++) begin
        iwp_r[i] <= '0;
        irp_r[i] <= '0;
        owp_r[i] <= '0;
        orp_r[i] <= '0;
        icnt_r[i] <= '0;
        ocnt_r[i] <= '0;
      end
    end else begin
      st_r <= st_nxt;
      awrdy_r <= awrdy_nxt;
      ardy_r <= ardy_nxt;
      bresp_r <= bresp_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      ier_r <= ier_nxt;
      cncr_r <= cncr_nxt;
      thr_r <= thr_nxt;
      icc_r <= icc_nxt;
      occ_r <= occ_nxt;
      need_r <= need_nxt;
      rdy_r <= rdy_nxt;
      ovl_r <= ovl_nxt;
      req_r <= req_nxt;
      s1_r <= samp_clk_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      iwp_r <= iwp_nxt;
      irp_r <= irp_nxt;
      owp_r <= owp_nxt;
      orp_r <= orp_nxt;
      icnt_r <= icnt_nxt;
      ocnt_r <= ocnt_nxt;
    end
  end

  // Sample storage has no reset; only pointers define what is valid
  always_ff @(posedge aclk) begin
    for (int i = 0; i < NF; i++) begin
      if (ipush[i]) in_mem[i][iwp_r[i]] <= s_axi_wdata[srcp_pkg::DW-1:0];
      if (opush[i]) out_mem[i][owp_r[i]] <= in_mem[i][irp_r[i]];
    end
  end

  cfg_total_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    int'(cncr_r[NW-1:0]) + int'(cncr_r[2*NW-1:NW]) + int'(cncr_r[3*NW-1:2*NW]) <= MC)
    else $error("channel total above limit");
  cfg_even_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !cncr_r[0] && !cncr_r[NW] && !cncr_r[2*NW])
    else $error("odd channel count accepted");
  poll_mode_a: assert property (
    @(posedge aclk) disable iff (!aresetn) !ier_r[0] |-> !req_r.in_irq[0])
    else $error("input interrupt while polling");
  consume_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    edge_v[0] && ctrl_r[0] && cncr_r[NW-1:0] != '0 && icnt_r[0] != '0 && !ipush[0]
    |=> icnt_r[0] == $past(icnt_r[0]) - 1'b1)
    else $error("sample edge did not consume");
  need_set_a: assert property (
    @(posedge aclk) disable iff (!aresetn) lo_v[1] |=> need_r[1] && req_r.in_dma[1])
    else $error("data-needed not set");
  ovl_flag_a: assert property (
    @(posedge aclk) disable iff (!aresetn) ovl_set |=> ovl_r)
    else $error("overload not flagged");
  need_clr_a: assert property (
    @(posedge aclk) disable iff (!aresetn) hi_v[0] |=> !need_r[0])
    else $error("data-needed not cleared");
  in_irq_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    need_r[0] && ier_r[0] |-> req_r.in_irq[0])
    else $error("input interrupt request missing");
  ovl_irq_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ovl_set && ier_nxt[srcp_pkg::IE_OVL] |=> req_r.ovl_irq)
    else $error("overload interrupt missing");
  out_dma_a: assert property (
    @(posedge aclk) disable iff (!aresetn) olo_v[0] |=> !req_r.out_dma[0])
    else $error("output request not withdrawn");
endmodule

// *** test/srcp_host_model.sv ***
// Purpose: bus master standing in for the host core or DMA on the register bus
// Assumes: AXI4-Lite, one write or one read under way at a time
// Notes: waits are unbounded here; the bench watchdog cuts a hang
`timescale 1ns/1ps
module srcp_host_model (
  input logic aclk,
  output logic [srcp_pkg::AW-1:0] awaddr,
  output logic awvalid,
  input logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input logic wready,
  input logic [1:0] bresp,
  input logic bvalid,
  output logic bready,
  output logic [srcp_pkg::AW-1:0] araddr,
  output logic arvalid,
  input logic arready,
  input logic [31:0] rdata,
  input logic [1:0] rresp,
  input logic rvalid,
  output logic rready
);
  initial begin
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
  end
  // Samples only ever move through bus registers
  task automatic wr(input logic [6:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) begin
        wvalid <= 1'b0;
        // Released data must not look valid
        wdata <= ~d;
      end
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule

// *** test/test_rate_converter_sample_port.sv ***
// Purpose: self-checking bench of the converter data port over its register bus
// Assumes: host model drives the bus, bench drives the sampling clocks
// Notes: sampling edges are slow pulses, well above the synchroniser delay
`timescale 1ns/1ps
module test_rate_converter_sample_port;
  logic aclk;
  logic aresetn;
  logic [srcp_pkg::NPAIR-1:0] samp_clk_in;
  srcp_pkg::srcp_req_type req;
  logic [6:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int errors;
  int samples_checked;
  srcp_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .samp_clk_in(samp_clk_in), .req(req));
  srcp_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  initial aclk = 1'b0;
  always #5 aclk = ~aclk;
  function automatic logic [6:0] ba(input logic [4:0] ix);
    return {ix, 2'b00};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [1:0] r;
    host.wr(a, d, r);
    check(32'(r), 32'(srcp_pkg::RESP_OK));
  endtask
  task automatic rd(input logic [6:0] a, input logic [31:0] want, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0] r;
    host.rd(a, v, r);
    check(v, want);
    check(32'(r), 32'(er));
  endtask
  // Flags change with the count, and one cycle after a threshold or channel-count write
  task automatic settle();
    repeat (3) @(posedge aclk);
  endtask
  // One sampling clock period; edge seen three clocks after the pin
  task automatic samp(input int p);
    samp_clk_in[p] <= 1'b1;
    repeat (4) @(posedge aclk);
    samp_clk_in[p] <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    errors++;
    wrap_up();
  end
  initial begin
    errors = 0;
    samples_checked = 0;
    aresetn = 1'b0;
    samp_clk_in = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    check(32'(req), 32'h0);
    rd(ba(srcp_pkg::IX_IER), 32'h0, srcp_pkg::RESP_OK);
    rd(ba(srcp_pkg::IX_THR), 32'h20, srcp_pkg::RESP_OK);
    rd(7'h08, 32'h0, srcp_pkg::RESP_ERR);
    $display("test reset done");
    wr(ba(srcp_pkg::IX_CNCR), 32'h0000000B);
    wr(ba(srcp_pkg::IX_CNCR), 32'h00000066);
    rd(ba(srcp_pkg::IX_CNCR), 32'h0, srcp_pkg::RESP_OK);
    wr(ba(srcp_pkg::IX_CNCR), 32'h00000002);
    rd(ba(srcp_pkg::IX_CNCR), 32'h2, srcp_pkg::RESP_OK);
    wr(ba(srcp_pkg::IX_CTRL), 32'h00000001);
    wr(ba(srcp_pkg::IX_IER), 32'h00000001);
    settle();
    check(32'(req.in_dma), 32'h1);
    check(32'(req.in_irq), 32'h1);
    wr(ba(srcp_pkg::IX_IER), 32'h00000000);
    settle();
    check(32'(req.in_irq), 32'h0);
    $display("test config done");
    // Channel-interleaved fill, 33 words per channel
    for (int i = 0; i < 66; i++) begin
      wr(ba(srcp_pkg::IX_DI[0]), 32'h100 + 32'(i));
      if (i < 2) rd(ba(srcp_pkg::IX_CCR), 32'((i + 1) % 2), srcp_pkg::RESP_OK);
    end
    settle();
    check(32'(req.in_dma), 32'h0);
    samp(0);
    check(32'(req.in_dma), 32'h0);
    samp(0);
    check(32'(req.in_dma), 32'h1);
    check(32'(req.out_dma), 32'h0);
    rd(ba(srcp_pkg::IX_DO[0]), 32'h100, srcp_pkg::RESP_OK);
    rd(ba(srcp_pkg::IX_DO[0]), 32'h101, srcp_pkg::RESP_OK);
    rd(ba(srcp_pkg::IX_STR), 32'h1, srcp_pkg::RESP_OK);
    $display("test routing done");
    wr(ba(srcp_pkg::IX_CNCR), 32'h00000022);
    wr(ba(srcp_pkg::IX_CTRL), 32'h00000003);
    wr(ba(srcp_pkg::IX_IER), 32'h00000040);
    samp(1);
    check(32'(req.ovl_irq), 32'h1);
    rd(ba(srcp_pkg::IX_STR), 32'h43, srcp_pkg::RESP_OK);
    wr(ba(srcp_pkg::IX_STR), 32'h00000040);
    rd(ba(srcp_pkg::IX_STR), 32'h03, srcp_pkg::RESP_OK);
    check(32'(req.ovl_irq), 32'h0);
    $display("test overload done");
    // Top up pair A by one word per channel, then move 32 per channel to the outputs
    wr(ba(srcp_pkg::IX_IER), 32'h00000048);
    wr(ba(srcp_pkg::IX_DI[0]), 32'h00000200);
    wr(ba(srcp_pkg::IX_DI[0]), 32'h00000201);
    for (int i = 0; i < 32; i++) samp(0);
    check(32'(req.out_dma), 32'h1);
    check(32'(req.out_irq), 32'h1);
    check(32'(req.ovl_irq), 32'h0);
    rd(ba(srcp_pkg::IX_STR), 32'h0B, srcp_pkg::RESP_OK);
    rd(ba(srcp_pkg::IX_DO[0]), 32'h102, srcp_pkg::RESP_OK);
    rd(ba(srcp_pkg::IX_DO[0]), 32'h103, srcp_pkg::RESP_OK);
    settle();
    check(32'(req.out_dma), 32'h1);
    rd(ba(srcp_pkg::IX_DO[0]), 32'h104, srcp_pkg::RESP_OK);
    settle();
    check(32'(req.out_dma), 32'h0);
    check(32'(req.out_irq), 32'h0);
    $display("test output done");
    wrap_up();
  end
endmodule
